/* File: shared/clk_ctrl_consts.vh */
// Register offsets, field positions, reset values and timing counts of the clock control block.
`ifndef CLK_CTRL_CONSTS_VH
`define CLK_CTRL_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define OFS_SYS_CLK_SEL    8'h00
`define OFS_FAST_OSC_CTRL  8'h04
`define OFS_IRQ_STATUS     8'h08
`define OFS_IRQ_MASK       8'h0c
`define OFS_HALT_CTRL      8'h10
`define OFS_MODE_STATUS    8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SEL_MSB            7
`define SEL_LSB            5
`define FAST_KEEP_BIT      1
`define SLOW_KEEP_BIT      0
`define FREQ_MSB           3
`define FREQ_LSB           2
`define STABLE_BIT         1
`define ENABLE_BIT         0

// ----------------------------------------------------------------------
// Reset values and the slow source select code
// ----------------------------------------------------------------------
`define SYS_CLK_SEL_RST    8'h00
`define FAST_OSC_CTRL_RST  8'h01
`define SEL_SLOW           3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      25
`define OSC_SETTLE_NS      1000
`define SETTLE_CYCLES      ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES        4

`endif

/* File: verilog/clk_glitchless_mux.v */
// Glitch-free two-way clock-enable handover between the current and the target source.
`timescale 1ns/1ps
module clk_glitchless_mux #(
    parameter SYNC_STAGES = 4
) (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       curTick,
    input  wire       tarTick,
    input  wire       switchReq,
    output reg        outTick,
    output reg        busy
);
    // ------------------------------------------------------------------
    // Handover sequencing
    // ------------------------------------------------------------------
    localparam S_RUN  = 3'b001;
    localparam S_WAIT = 3'b010;
    localparam S_ARM  = 3'b100;

    reg [2:0]  state_q;
    reg [7:0]  cnt_q;

    // The old enable is allowed to finish its period, then counted out over current ticks before
    // the new one is armed on its own first tick, which can come one cycle after the last old tick.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= S_RUN;
            cnt_q   <= 8'h00;
            outTick <= 1'b0;
            busy    <= 1'b0;
        end else begin
            case (state_q)
                S_RUN: begin
                    outTick <= curTick;
                    if (switchReq) begin
                        state_q <= S_WAIT;
                        cnt_q   <= 8'h00;
                        busy    <= 1'b1;
                    end
                end
                S_WAIT: begin
                    outTick <= curTick;
                    if (curTick) begin
                        if (cnt_q == SYNC_STAGES[7:0] - 8'h01) begin
                            state_q <= S_ARM;
                        end
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                S_ARM: begin
                    outTick <= 1'b0;
                    if (tarTick) begin
                        outTick <= 1'b1;
                        state_q <= S_RUN;
                        busy    <= 1'b0;
                    end
                end
                default: begin
                    state_q <= S_RUN;
                    outTick <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: verilog/sys_clock_control.v */
// System clock selection, halt oscillator keeping and fast oscillator control with AXI4-Lite registers.
// Functional notes
// R1: select 000 fast, 001..110 divide 2..64, 111 slow.
// R2: unused bits read zero, writes ignored.
// R3: fast keep resets 0, keeps fast oscillator in halt.
// R4: slow keep resets 0, keeps slow oscillator in halt.
// R5: switch ends within four current periods plus resync.
// R6: software waits out the switch delay.
// R7: frequency field resets 00: 4, 8, 12, 4 MHz.
// R8: new frequency applies only once stable.
// R9: stable flag resets 0, clears on enable or change.
// R10: enable resets 1, runs the fast oscillator.
// R11: software matches frequency to the configuration option.
// R12: halt keep bits pick sleep, idle0, idle1 or idle2.
// R13: slow mode fast oscillator follows its enable.
// R14: handover glitch-free, no shortened periods; the gap between the last old and first new tick can be one cycle.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "clk_ctrl_consts.vh"
module sys_clock_control #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter SLOW_DIV      = 1250
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        haltReq,
    output reg         sysClkEn,
    output reg         fastOscRun,
    output reg         slowOscRun,
    output reg  [1:0]  fastOscFreq,
    output reg         irq
);
    // ------------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------------
    localparam M_FAST  = 6'b000001;
    localparam M_SLOW  = 6'b000010;
    localparam M_SLEEP = 6'b000100;
    localparam M_IDLE0 = 6'b001000;
    localparam M_IDLE1 = 6'b010000;
    localparam M_IDLE2 = 6'b100000;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [2:0]  srcSel_q;
    reg        fastKeep_q;
    reg        slowKeep_q;
    reg [1:0]  freqSel_q;
    reg        fastEn_q;
    reg        stable_q;
    reg [2:0]  irqStat_q;
    reg [2:0]  irqMask_q;
    reg        halted_q;
    reg [5:0]  mode_q;
    reg [15:0] settleCnt_q;
    reg [1:0]  appliedFreq_q;
    reg [6:0]  fastDiv_q;
    reg [15:0] slowDiv_q;
    reg        slowTick_q;
    reg [2:0]  activeSel_q;
    reg        switchReq_q;
    reg        busyPrev_q;
    reg        haltS1_q;
    reg        haltS2_q;
    reg        awHeld_q;
    reg        wHeld_q;
    reg [7:0]  awAddr_q;
    reg [31:0] wData_q;
    reg [3:0]  wStrb_q;

    wire       muxTick;
    wire       muxBusy;
    reg        curTick;
    reg        tarTick;
    reg        settleDone;
    reg [31:0] rdWord;
    reg [5:0]  modeNext;

    // ------------------------------------------------------------------
    // Halt input synchroniser
    // ------------------------------------------------------------------
    // The halt level arrives from the core's pin domain, so it is retimed twice.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            haltS1_q <= 1'b0;
            haltS2_q <= 1'b0;
        end else begin
            haltS1_q <= haltReq;
            haltS2_q <= haltS1_q;
        end
    end

    // ------------------------------------------------------------------
    // Source dividers
    // ------------------------------------------------------------------
    // The fast divider is a free counter; its low bits all at one mark each divided tick.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fastDiv_q  <= 7'h00;
            slowDiv_q  <= 16'h0000;
            slowTick_q <= 1'b0;
        end else begin
            fastDiv_q  <= fastDiv_q + 7'h01;
            slowTick_q <= (slowDiv_q == 16'h0000);
            if (slowDiv_q == SLOW_DIV[15:0] - 16'h0001) begin
                slowDiv_q <= 16'h0000;
            end else begin
                slowDiv_q <= slowDiv_q + 16'h0001;
            end
        end
    end

    // Tick of a given selection code; the fast source gates on the stable flag.
    function tickOf;
        input [2:0] sel;
        input [6:0] div;
        input       slowTk;
        input       stbl;
        begin
            case (sel)
                3'h0:    tickOf = stbl;
                3'h1:    tickOf = stbl & (div[0:0] == 1'h1);
                3'h2:    tickOf = stbl & (div[1:0] == 2'h3);
                3'h3:    tickOf = stbl & (div[2:0] == 3'h7);
                3'h4:    tickOf = stbl & (div[3:0] == 4'hf);
                3'h5:    tickOf = stbl & (div[4:0] == 5'h1f);
                3'h6:    tickOf = stbl & (div[5:0] == 6'h3f);
                default: tickOf = slowTk;
            endcase
        end
    endfunction

    // Current and target enables for the handover.
    always @* begin
        curTick    = tickOf((busyPrev_q & ~muxBusy) ? srcSel_q : activeSel_q, fastDiv_q, slowTick_q, stable_q); // R14
        tarTick    = tickOf(srcSel_q, fastDiv_q, slowTick_q, stable_q); // R1 R8
    end

    clk_glitchless_mux #(
        .SYNC_STAGES (`SYNC_STAGES)
    ) u_mux (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .curTick   (curTick),
        .tarTick   (tarTick),
        .switchReq (switchReq_q),
        .outTick   (muxTick),
        .busy      (muxBusy)
    );

    // Active selection moves in the cycle after the handover ends, so the old source never ticks again.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            activeSel_q <= 3'h0;
            switchReq_q <= 1'b0;
            busyPrev_q  <= 1'b0;
        end else begin
            switchReq_q <= 1'b0;
            busyPrev_q  <= muxBusy;
            if (!muxBusy && !busyPrev_q && !switchReq_q && activeSel_q != srcSel_q) begin
                switchReq_q <= 1'b1; // R5
            end
            if (busyPrev_q && !muxBusy) begin
                activeSel_q <= srcSel_q; // R14
            end
        end
    end

    // ------------------------------------------------------------------
    // Fast oscillator settle timer
    // ------------------------------------------------------------------
    always @* begin
        settleDone = (settleCnt_q == 16'h0000);
    end

    // Stable flag drops while the fast oscillator is stopped or on a frequency change, rises after the settle count.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stable_q      <= 1'b0; // R9
            settleCnt_q   <= SETTLE_CYCLES[15:0];
            appliedFreq_q <= 2'h0;
        end else if (!fastOscRun) begin
            stable_q    <= 1'b0;
            settleCnt_q <= SETTLE_CYCLES[15:0];
        end else if (freqSel_q != appliedFreq_q) begin
            stable_q      <= 1'b0; // R9
            settleCnt_q   <= SETTLE_CYCLES[15:0];
            appliedFreq_q <= freqSel_q;
        end else if (!settleDone) begin
            settleCnt_q <= settleCnt_q - 16'h0001;
        end else begin
            stable_q <= 1'b1; // R9
        end
    end

    // ------------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------------
    always @* begin
        case ({fastKeep_q, slowKeep_q})
            2'b00:   modeNext = M_SLEEP; // R12
            2'b01:   modeNext = M_IDLE0; // R12
            2'b11:   modeNext = M_IDLE1; // R12
            default: modeNext = M_IDLE2; // R12
        endcase
        if (!haltS2_q) begin
            modeNext = (activeSel_q == `SEL_SLOW) ? M_SLOW : M_FAST;
        end
    end

    // Mode and oscillator outputs; a halt entry or exit also raises a status event.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q      <= M_FAST;
            halted_q    <= 1'b0;
            sysClkEn    <= 1'b0;
            fastOscRun  <= 1'b0;
            slowOscRun  <= 1'b1;
            fastOscFreq <= 2'h0;
        end else begin
            mode_q      <= modeNext;
            halted_q    <= haltS2_q;
            sysClkEn    <= muxTick & ~haltS2_q;
            fastOscRun  <= fastEn_q & (!haltS2_q | fastKeep_q); // R3 R10 R13
            slowOscRun  <= !haltS2_q | slowKeep_q; // R4
            if (stable_q && freqSel_q == appliedFreq_q) begin
                fastOscFreq <= (freqSel_q == 2'h3) ? 2'h0 : freqSel_q; // R7 R8
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    wire       wrGo   = awHeld_q && wHeld_q && !s_axi_bvalid;
    wire [2:0] events = {stable_q & (!fastOscRun || freqSel_q != appliedFreq_q), switchReq_q, halted_q != haltS2_q};

    // Address and data are held independently; the write commits once both are in.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= 8'h00;
            wData_q       <= 32'h0;
            wStrb_q       <= 4'h0;
            srcSel_q      <= 3'h0;
            fastKeep_q    <= 1'b0; // R3
            slowKeep_q    <= 1'b0; // R4
            freqSel_q     <= 2'h0; // R7
            fastEn_q      <= 1'b1; // R10
            irqMask_q     <= 3'h0;
            irqStat_q     <= 3'h0;
            irq           <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q      <= 1'b1;
                awAddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q      <= 1'b1;
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            irqStat_q <= irqStat_q | events;
            if (wrGo) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                if (wStrb_q[0]) begin
                    case (awAddr_q)
                        `OFS_SYS_CLK_SEL: begin
                            srcSel_q   <= wData_q[`SEL_MSB:`SEL_LSB]; // R1 R2
                            fastKeep_q <= wData_q[`FAST_KEEP_BIT];
                            slowKeep_q <= wData_q[`SLOW_KEEP_BIT];
                        end
                        `OFS_FAST_OSC_CTRL: begin
                            freqSel_q <= wData_q[`FREQ_MSB:`FREQ_LSB]; // R2
                            fastEn_q  <= wData_q[`ENABLE_BIT];
                        end
                        `OFS_IRQ_STATUS: irqStat_q <= (irqStat_q & ~wData_q[2:0]) | events;
                        `OFS_IRQ_MASK:   irqMask_q <= wData_q[2:0];
                        `OFS_HALT_CTRL, `OFS_MODE_STATUS: begin
                        end
                        default: s_axi_bresp <= 2'h2;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    // Unused positions are zero in every word.
    always @* begin
        rdWord = 32'h0;
        case (s_axi_araddr)
            `OFS_SYS_CLK_SEL:   rdWord = {24'h0, srcSel_q, 3'h0, fastKeep_q, slowKeep_q}; // R2
            `OFS_FAST_OSC_CTRL: rdWord = {28'h0, freqSel_q, stable_q, fastEn_q}; // R2 R9
            `OFS_IRQ_STATUS:    rdWord = {29'h0, irqStat_q};
            `OFS_IRQ_MASK:      rdWord = {29'h0, irqMask_q};
            `OFS_HALT_CTRL:     rdWord = {31'h0, halted_q};
            `OFS_MODE_STATUS:   rdWord = {22'h0, muxBusy, activeSel_q, mode_q};
            default:            rdWord = 32'h0;
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdWord;
                s_axi_rresp   <= (s_axi_araddr > `OFS_MODE_STATUS || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

/* File: dv/sys_clock_control_chk.sv */
// Port-level assertions for the system clock control block.
`timescale 1ns/1ps
module sys_clock_control_chk (
    input logic        ref_clk,
    input logic        rst,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        haltReq,
    input logic        sysClkEn,
    input logic        slowOscRun,
    input logic        fastOscRun,
    input logic [1:0]  fastOscFreq
);
    // ------------------------------------------------------------------
    // Clock and oscillator relations
    // ------------------------------------------------------------------
    // All checks live in the single ref_clk domain.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Five cycles cover the two-flop halt synchroniser plus the output register.
    property p_haltGatesClk; haltReq [*5] |-> !sysClkEn; endproperty
    a_haltGatesClk: assert property (p_haltGatesClk) else $error("clock enable while halted");
    property p_slowRunsAwake; !haltReq [*5] |-> slowOscRun; endproperty
    a_slowRunsAwake: assert property (p_slowRunsAwake) else $error("slow oscillator off while awake");
    property p_freqFolded; fastOscFreq != 2'h3; endproperty
    a_freqFolded: assert property (p_freqFolded) else $error("frequency code three applied");
    property p_freqNeedsRun; !$stable(fastOscFreq) |-> fastOscRun; endproperty
    a_freqNeedsRun: assert property (p_freqNeedsRun) else $error("frequency changed while stopped");

    // ------------------------------------------------------------------
    // Register bus relations
    // ------------------------------------------------------------------
    property p_bAfterBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_bAfterBoth: assert property (p_bAfterBoth) else $error("write response late");
    property p_bOnce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    a_bOnce: assert property (p_bOnce) else $error("write response not retired");
    property p_rAfterAr; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_rAfterAr: assert property (p_rAfterAr) else $error("read data late");
    property p_rOnce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    a_rOnce: assert property (p_rOnce) else $error("read response not retired");
    property p_upperZero; s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h0; endproperty
    a_upperZero: assert property (p_upperZero) else $error("unused read bits set");
    property p_errData; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
    a_errData: assert property (p_errData) else $error("refused read returned data");
    property p_bCodes; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
    a_bCodes: assert property (p_bCodes) else $error("bad write response code");
endmodule

bind sys_clock_control sys_clock_control_chk u_chk (.*);

/* File: dv/tb_top.sv */
// Self-checking bench for the system clock control block.
`timescale 1ns/1ps
`include "clk_ctrl_consts.vh"
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top;
    localparam int SLOW_DIV = 8;
    localparam int LIMIT    = 20000;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  awAddr  = 8'h00;
    logic        awValid = 1'b0;
    logic [31:0] wData   = 32'h0;
    logic        wValid  = 1'b0;
    logic [7:0]  arAddr  = 8'h00;
    logic        arValid = 1'b0;
    logic        haltReq = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid, sysClkEn, fastOscRun, slowOscRun, irq;
    logic [1:0]  bResp, rResp, fastOscFreq, f, prevFreq;
    logic [31:0] rData, d;
    logic [1:0]  r;
    int          errors, checksDone, cycles, p0, p, cur, tgt, t0;
    int          modeBit [4] = '{2, 3, 5, 4};

    // The handshake ready inputs stay high so every response is taken at once.
    sys_clock_control #(.SETTLE_CYCLES(4), .SLOW_DIV(SLOW_DIV)) u_sys_clock_control (
        .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1), .haltReq(haltReq),
        .sysClkEn(sysClkEn), .fastOscRun(fastOscRun), .slowOscRun(slowOscRun),
        .fastOscFreq(fastOscFreq), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------------
    // Free-running 40 MHz reference.
    initial forever #12.5 ref_clk = ~ref_clk;

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("Error at %0t: timeout", $time);
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------------
    // Each channel is released only at the edge where its ready was seen.
    task automatic axiWr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
        awAddr  <= a;
        wData   <= dat;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid);
        rsp = bResp;
    endtask

    task automatic axiRd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        arAddr  <= a;
        arValid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arReady) arValid <= 1'b0;
        end while (!rValid);
        dat = rData;
        rsp = rResp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic [1:0] rsp;
        axiWr(a, dat, rsp);
        `CHK(rsp, 2'h0)
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] dat;
        logic [1:0]  rsp;
        axiRd(a, dat, rsp);
        `CHK(dat, e)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Polling is bounded so a flag that never rises shows up as a mismatch.
    task automatic waitStable();
        int n;
        n = 0;
        do begin axiRd(`OFS_FAST_OSC_CTRL, d, r); n++; end while (!d[1] && n < 40);
        `CHK(d[1], 1'b1)
    endtask

    // Busy may not be up yet at the first read, so the active select must match too.
    task automatic waitSwitch(input logic [2:0] s);
        do axiRd(`OFS_MODE_STATUS, d, r); while ((d[9] || d[8:6] != s) && cycles - t0 < 3000);
    endtask

    task automatic measPeriod(output int per);
        do @(posedge ref_clk); while (!sysClkEn);
        per = 0;
        do begin @(posedge ref_clk); per++; end while (!sysClkEn);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        `CHK(slowOscRun, 1'b1)
        rdChk(`OFS_SYS_CLK_SEL, 32'h0);
        waitStable();
        rdChk(`OFS_FAST_OSC_CTRL, 32'h3);
        `CHK(fastOscRun, 1'b1)
        axiWr(8'h20, 32'h1, r);
        `CHK(r, 2'h2)
        axiRd(8'h20, d, r);
        `CHK({r, d}, {2'h2, 32'h0})
        // Codes 1, 2, 3, 0 with the unused bits 31..4 written as ones.
        prevFreq = 2'h0;
        for (int i = 0; i < 4; i++) begin
            f = 2'(i + 1);
            wr(`OFS_FAST_OSC_CTRL, {24'hffffff, 4'hf, f, 2'b01});
            tick(2);
            `CHK(fastOscFreq, prevFreq)
            waitStable();
            prevFreq = (f == 2'h3) ? 2'h0 : f;
            `CHK(fastOscFreq, prevFreq)
            rdChk(`OFS_FAST_OSC_CTRL, {28'h0, f, 2'b11});
        end
        // Walk select codes 1 to 7 and compare the enable period with the undivided one shifted by the code, or with SLOW_DIV for 7.
        wr(`OFS_IRQ_STATUS, 32'h7);
        measPeriod(p0);
        cur = p0;
        for (int k = 1; k < 8; k++) begin
            tgt = (k == 7) ? SLOW_DIV : p0 << k;
            t0 = cycles;
            wr(`OFS_SYS_CLK_SEL, {24'h0, 3'(k), 5'h1c});
            waitSwitch(3'(k));
            `CHK(cycles - t0 <= 6 * cur + 2 * tgt + 16, 1'b1)
            rdChk(`OFS_SYS_CLK_SEL, {24'h0, 3'(k), 5'h0});
            rdChk(`OFS_MODE_STATUS, {23'h0, 3'(k), (k == 7) ? 6'h02 : 6'h01});
            measPeriod(p);
            `CHK(p, tgt)
            cur = tgt;
        end
        // Fast oscillator follows its enable while running from the slow source.
        wr(`OFS_FAST_OSC_CTRL, 32'h0);
        tick(4);
        `CHK(fastOscRun, 1'b0)
        rdChk(`OFS_FAST_OSC_CTRL, 32'h0);
        wr(`OFS_FAST_OSC_CTRL, 32'h1);
        waitStable();
        `CHK(fastOscRun, 1'b1)
        t0 = cycles;
        wr(`OFS_SYS_CLK_SEL, 32'h0);
        waitSwitch(3'h0);
        `CHK(cycles - t0 <= 6 * SLOW_DIV + 2 * p0 + 16, 1'b1)
        measPeriod(p);
        `CHK(p, p0)
        // Each pair of keep bits under halt, with the halt interrupt unmasked.
        wr(`OFS_IRQ_STATUS, 32'h7);
        wr(`OFS_IRQ_MASK, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(`OFS_SYS_CLK_SEL, {30'h0, 2'(k)});
            haltReq <= 1'b1;
            tick(6);
            `CHK({sysClkEn, fastOscRun, slowOscRun}, {1'b0, 2'(k)})
            rdChk(`OFS_MODE_STATUS, 32'h1 << modeBit[k]);
            `CHK(irq, 1'b1)
            haltReq <= 1'b0;
            tick(6);
            `CHK({fastOscRun, slowOscRun}, 2'b11)
            wr(`OFS_IRQ_STATUS, 32'h1);
            tick(2);
            `CHK(irq, 1'b0)
        end
        // A masked event still latches its status bit.
        wr(`OFS_IRQ_MASK, 32'h0);
        haltReq <= 1'b1;
        tick(6);
        `CHK(irq, 1'b0)
        axiRd(`OFS_IRQ_STATUS, d, r);
        `CHK(d[0], 1'b1)
        haltReq <= 1'b0;
        tick(6);
        give_verdict();
    end
endmodule
